// file: design/blink_timer.v
`timescale 1ns/1ps
`default_nettype none
// counts a whole-ms duration, pulses done when it elapses and starts over; load realigns it
module blink_timer #(
   parameter integer TICKS_PER_MS = 200000
)
(
   input wire CLK_SYS,
   input wire RSTN,
   input wire load,
   input wire [10:0] ms,
   output reg done
);
   reg [17:0] tick_reg;
   reg [10:0] ms_reg;
   // prescaler runs down to one ms tick, then the ms counter steps
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         tick_reg <= 18'h0_0000;
         ms_reg <= 11'h000;
         done <= 1'b0;
      end
      else if (load)
      begin
         tick_reg <= TICKS_PER_MS[17:0] - 18'h0_0001;
         ms_reg <= ms;
         done <= 1'b0;
      end
      else if (ms_reg != 11'h000)
      begin
         done <= 1'b0;
         if (tick_reg == 18'h0_0000)
         begin
            tick_reg <= TICKS_PER_MS[17:0] - 18'h0_0001;
            // reload in the same cycle, so a period is exactly ms milliseconds long
            ms_reg <= (ms_reg == 11'h001) ? ms : ms_reg - 11'h001;
            done <= (ms_reg == 11'h001);
         end
         else
         begin
            tick_reg <= tick_reg - 18'h0_0001;
         end
      end
      else
      begin
         done <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: design/can_node_config.v
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "can_node_regs.vh"
module can_node_config #(
   parameter integer TICKS_PER_MS = `TICKS_PER_MS
)
(
   input wire CLK_SYS,
   input wire RSTN,
   input wire [3:0] TENS_ROTARY_SWITCH,
   input wire [3:0] UNITS_ROTARY_SWITCH,
   input wire [3:0] NVM_RATE,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   output reg NVM_WRITE,
   output reg [3:0] NVM_WDATA,
   output reg [3:0] LINK_RATE,
   output reg [6:0] NODE_NUMBER,
   output reg SELECT_MODE,
   output reg MODULE_STATE_LED_GREEN,
   output reg MODULE_STATE_LED_RED,
   output reg NETWORK_STATE_LED_GREEN,
   output reg NETWORK_STATE_LED_RED
);
   localparam ST_INIT = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_SEL = 2'h2;
   localparam ST_CONF = 2'h3;
   localparam [10:0] MS_SEL = `T_SEL_HALF_MS;
   localparam [10:0] MS_FLASH = `T_FLASH_MS;
   localparam [10:0] MS_ERR = `T_ERR_MS;

   reg [3:0] tens_meta_reg, tens_reg, units_meta_reg, units_reg;
   reg [3:0] nvm_meta_reg, nvm_reg;
   reg [1:0] state_reg;
   reg [1:0] init_cnt_reg;
   reg [3:0] rate_code_reg;
   reg [31:0] ctrl_reg;
   reg sel_phase_reg;
   reg err_phase_reg;
   reg blink_phase_reg;
   // module LED count sequence
   reg [4:0] ms_step_reg;
   reg ms_on_reg;
   // network LED sequences
   reg [3:0] ns_red_step_reg;
   reg [3:0] ns_grn_step_reg;
   wire sel_done, flash_done, err_done;
   wire flash_tick = flash_done;
   wire [3:0] shown_code;
   wire [1:0] nmt;
   wire [6:0] node_raw;
   reg [2:0] red_flashes;
   reg [3:0] ms_target;

   // ms timers restart themselves; the 200 ms beat also times the 1 s dark (five beats)
   blink_timer #(.TICKS_PER_MS(TICKS_PER_MS)) sel_tmr (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
      .load(state_reg == ST_INIT), .ms(MS_SEL), .done(sel_done));
   blink_timer #(.TICKS_PER_MS(TICKS_PER_MS)) flash_tmr (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
      .load(state_reg == ST_INIT), .ms(MS_FLASH), .done(flash_done));
   blink_timer #(.TICKS_PER_MS(TICKS_PER_MS)) err_tmr (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
      .load(state_reg == ST_INIT), .ms(MS_ERR), .done(err_done));

   // switches and stored rate come from off-chip, so two flops first
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         tens_meta_reg <= 4'h0;
         tens_reg <= 4'h0;
         units_meta_reg <= 4'h0;
         units_reg <= 4'h0;
         nvm_meta_reg <= 4'h0;
         nvm_reg <= 4'h0;
      end
      else
      begin
         tens_meta_reg <= TENS_ROTARY_SWITCH;
         tens_reg <= tens_meta_reg;
         units_meta_reg <= UNITS_ROTARY_SWITCH;
         units_reg <= units_meta_reg;
         nvm_meta_reg <= NVM_RATE;
         nvm_reg <= nvm_meta_reg;
      end
   end

   // node number: tens times ten plus units
   assign node_raw = {tens_reg, 3'b000} + {2'b00, tens_reg, 1'b0} + {3'b000, units_reg};

   // start-up sampling, selection entry, confirmation and storage
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         state_reg <= ST_INIT;
         init_cnt_reg <= 2'h0;
         rate_code_reg <= `RATE_DEFAULT;
         NODE_NUMBER <= `NODE_MIN;
         LINK_RATE <= `RATE_DEFAULT;
         SELECT_MODE <= 1'b0;
         NVM_WRITE <= 1'b0;
         NVM_WDATA <= 4'h0;
      end
      else
      begin
         NVM_WRITE <= 1'b0;
         case (state_reg)
            ST_INIT:
            begin
               // wait until the synchronisers hold real pin values
               init_cnt_reg <= init_cnt_reg + 2'h1;
               if (init_cnt_reg == 2'h3)
               begin
                  rate_code_reg <= nvm_reg;
                  LINK_RATE <= nvm_reg;
                  if (tens_reg == `SW_SELECT && units_reg == `SW_SELECT)
                  begin
                     state_reg <= ST_SEL;
                     SELECT_MODE <= 1'b1;
                  end
                  else
                  begin
                     state_reg <= ST_RUN;
                     // held until next reset; 00 becomes 01
                     NODE_NUMBER <= (node_raw == 7'h00) ? `NODE_MIN : node_raw;
                  end
               end
            end
            ST_SEL:
            begin
               if (tens_reg == `SW_ZERO && units_reg != `SW_ZERO)
               begin
                  state_reg <= ST_CONF;
                  rate_code_reg <= units_reg;
                  NVM_WRITE <= 1'b1;
                  NVM_WDATA <= units_reg;
               end
            end
            ST_RUN, ST_CONF:
            begin
               state_reg <= state_reg; // link rate changes only after reset
            end
            default:
            begin
               state_reg <= ST_INIT;
            end
         endcase
      end
   end

   // the code the module LED counts out: selected position or stored code
   assign shown_code = (state_reg == ST_SEL && units_reg != `SW_ZERO) ? units_reg
                       : rate_code_reg;

   // 500 ms period selection blink and 50 ms error blink phases
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         sel_phase_reg <= 1'b0;
         err_phase_reg <= 1'b0;
         blink_phase_reg <= 1'b0;
      end
      else
      begin
         if (sel_done)
            sel_phase_reg <= ~sel_phase_reg;
         if (err_done)
            err_phase_reg <= ~err_phase_reg;
         if (flash_tick)
            blink_phase_reg <= ~blink_phase_reg;
      end
   end

   // count sequence: n flashes of 200 ms on/off, then 1 s dark (five beats)
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         ms_step_reg <= 5'h00;
      end
      else if (flash_tick)
      begin
         if (ms_step_reg >= {shown_code, 1'b0} + 5'h04)
            ms_step_reg <= 5'h00;
         else
            ms_step_reg <= ms_step_reg + 5'h01;
      end
   end

   // red flash count for the network LED from the stack's status bits
   always @*
   begin
      red_flashes = 3'h0;
      if (ctrl_reg[`CTRL_BUSOFF])
         red_flashes = 3'h3;
      else if (ctrl_reg[`CTRL_GUARD])
         red_flashes = 3'h2;
      else if (ctrl_reg[`CTRL_WARN])
         red_flashes = 3'h1;
      ms_target = {1'b0, red_flashes};
   end

   assign nmt = ctrl_reg[`CTRL_NMT_MSB:`CTRL_NMT_LSB];

   // network LED pattern steps; 1 s dark is five 200 ms beats
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         ns_red_step_reg <= 4'h0;
         ns_grn_step_reg <= 4'h0;
      end
      else if (flash_tick)
      begin
         ns_red_step_reg <= (ns_red_step_reg >= {ms_target[2:0], 1'b0} + 4'h4) ? 4'h0
                            : ns_red_step_reg + 4'h1;
         ns_grn_step_reg <= (ns_grn_step_reg >= 4'h6) ? 4'h0 : ns_grn_step_reg + 4'h1;
      end
   end

   // LED drivers, all registered
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         MODULE_STATE_LED_GREEN <= 1'b0;
         MODULE_STATE_LED_RED <= 1'b0;
         NETWORK_STATE_LED_GREEN <= 1'b0;
         NETWORK_STATE_LED_RED <= 1'b0;
         ms_on_reg <= 1'b0;
      end
      else
      begin
         ms_on_reg <= (ms_step_reg < {shown_code, 1'b0}) & ~ms_step_reg[0];
         case (state_reg)
            ST_SEL:
            begin
               if (units_reg == `SW_ZERO)
               begin
                  MODULE_STATE_LED_GREEN <= 1'b0;
                  MODULE_STATE_LED_RED <= ms_on_reg;
                  NETWORK_STATE_LED_GREEN <= sel_phase_reg;
               end
               else
               begin
                  // green count of the position; no steady sel blink on module LED
                  MODULE_STATE_LED_GREEN <= ms_on_reg;
                  MODULE_STATE_LED_RED <= 1'b0;
                  NETWORK_STATE_LED_GREEN <= sel_phase_reg;
               end
               NETWORK_STATE_LED_RED <= 1'b0;
            end
            ST_CONF:
            begin
               MODULE_STATE_LED_GREEN <= 1'b0;
               MODULE_STATE_LED_RED <= ms_on_reg;
               NETWORK_STATE_LED_GREEN <= 1'b0;
               NETWORK_STATE_LED_RED <= 1'b0;
            end
            ST_RUN:
            begin
               if (ctrl_reg[`CTRL_DRIVE_ERR])
               begin
                  MODULE_STATE_LED_GREEN <= 1'b0;
                  MODULE_STATE_LED_RED <= err_phase_reg;
               end
               else
               begin
                  MODULE_STATE_LED_GREEN <= blink_phase_reg;
                  MODULE_STATE_LED_RED <= 1'b0;
               end
               NETWORK_STATE_LED_RED <= (red_flashes != 3'h0)
                  & (ns_red_step_reg < {red_flashes, 1'b0}) & ~ns_red_step_reg[0];
               case (nmt)
                  `NMT_OPER: NETWORK_STATE_LED_GREEN <= 1'b1;
                  `NMT_PREOP: NETWORK_STATE_LED_GREEN <= blink_phase_reg;
                  `NMT_STOPPED: NETWORK_STATE_LED_GREEN <= (ns_grn_step_reg == 4'h0);
                  default: NETWORK_STATE_LED_GREEN <= 1'b0;
               endcase
            end
            default:
            begin
               MODULE_STATE_LED_GREEN <= 1'b0;
               MODULE_STATE_LED_RED <= 1'b0;
               NETWORK_STATE_LED_GREEN <= 1'b0;
               NETWORK_STATE_LED_RED <= 1'b0;
            end
         endcase
      end
   end

   // wishbone slave: one wait state, ack dropped after one cycle
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
         ctrl_reg <= `CTRL_RESET;
      end
      else
      begin
         WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
         if (WB_CYC_I & WB_STB_I & ~WB_ACK_O)
         begin
            if (WB_WE_I && WB_ADR_I == `ADDR_CTRL && WB_SEL_I[0])
               ctrl_reg[7:0] <= {2'b00, WB_DAT_I[5:0]};
            case (WB_ADR_I)
               `ADDR_CTRL: WB_DAT_O <= ctrl_reg;
               `ADDR_STATUS: WB_DAT_O <= {24'h00_0000, MODULE_STATE_LED_GREEN,
                  MODULE_STATE_LED_RED, NETWORK_STATE_LED_GREEN, NETWORK_STATE_LED_RED,
                  1'b0, SELECT_MODE, state_reg};
               `ADDR_NODE: WB_DAT_O <= {25'h000_0000, NODE_NUMBER};
               `ADDR_NVM: WB_DAT_O <= {24'h00_0000, rate_code_reg, LINK_RATE};
               `ADDR_ID: WB_DAT_O <= `ID_VALUE; // arbitrary value
               default: WB_DAT_O <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: inc/can_node_regs.vh
`ifndef CAN_NODE_REGS_VH
`define CAN_NODE_REGS_VH
// wishbone register offsets (byte addresses)
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_NODE 8'h08
`define ADDR_NVM 8'h0C
`define ADDR_ID 8'h10
// control register fields
`define CTRL_DRIVE_ERR 0
`define CTRL_WARN 1
`define CTRL_GUARD 2
`define CTRL_BUSOFF 3
`define CTRL_NMT_LSB 4
`define CTRL_NMT_MSB 5
`define CTRL_RESET 32'h0000_0000
// network management states
`define NMT_STOPPED 2'h0
`define NMT_PREOP 2'h1
`define NMT_OPER 2'h2
// switch special values
`define SW_SELECT 4'h9
`define SW_ZERO 4'h0
`define NODE_MIN 7'h01
`define RATE_DEFAULT 4'h1
// timing in ms and clock rate
`define CLK_HZ 200000000
`define T_SEL_HALF_MS 250
`define T_FLASH_MS 200
`define T_ERR_MS 50
`define T_DARK_MS 1000
`define TICKS_PER_MS (`CLK_HZ / 1000)
// arbitrary identification value
`define ID_VALUE 32'h0000_A5A5
`endif

// file: tb/can_node_config_sva.sv
`timescale 1ns/1ps
`default_nettype none
module can_node_config_sva (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic NVM_WRITE,
   input wire logic [3:0] NVM_WDATA,
   input wire logic [3:0] LINK_RATE,
   input wire logic [6:0] NODE_NUMBER,
   input wire logic SELECT_MODE,
   input wire logic MODULE_STATE_LED_GREEN,
   input wire logic MODULE_STATE_LED_RED,
   input wire logic NETWORK_STATE_LED_RED
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   logic [4:0] up_reg;
   // cycles since reset release; start-up sampling is long over once saturated
   always @(posedge CLK_SYS)
   begin
      if (!RSTN)
         up_reg <= 5'h00;
      else if (up_reg != 5'h1f)
         up_reg <= up_reg + 5'h01;
   end
   a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack late");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack too long");
   a_nvm_pulse: assert property (NVM_WRITE |=> !NVM_WRITE)
      else $error("store pulse too long");
   a_nvm_code: assert property (NVM_WRITE |-> NVM_WDATA != 4'h0 && NVM_WDATA <= 4'h9)
      else $error("stored code out of range");
   a_nvm_sel: assert property (NVM_WRITE |-> $past(SELECT_MODE))
      else $error("store outside selection");
   a_sel_node: assert property (SELECT_MODE |-> NODE_NUMBER == 7'h01)
      else $error("node in selection");
   a_node_range: assert property (NODE_NUMBER != 7'h00 && NODE_NUMBER != 7'h63)
      else $error("node out of range");
   a_node_held: assert property (up_reg == 5'h1f |-> $stable(NODE_NUMBER))
      else $error("node changed");
   a_link_held: assert property (up_reg == 5'h1f |-> $stable(LINK_RATE))
      else $error("link rate changed");
   a_ms_excl: assert property (!(MODULE_STATE_LED_GREEN && MODULE_STATE_LED_RED))
      else $error("module led both colours");
   a_sel_ns: assert property (SELECT_MODE |-> !NETWORK_STATE_LED_RED)
      else $error("network red in selection");
endmodule
bind can_node_config can_node_config_sva i_sva (
   .CLK_SYS(CLK_SYS),
   .RSTN(RSTN),
   .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I),
   .WB_ACK_O(WB_ACK_O),
   .NVM_WRITE(NVM_WRITE),
   .NVM_WDATA(NVM_WDATA),
   .LINK_RATE(LINK_RATE),
   .NODE_NUMBER(NODE_NUMBER),
   .SELECT_MODE(SELECT_MODE),
   .MODULE_STATE_LED_GREEN(MODULE_STATE_LED_GREEN),
   .MODULE_STATE_LED_RED(MODULE_STATE_LED_RED),
   .NETWORK_STATE_LED_RED(NETWORK_STATE_LED_RED)
);
`default_nettype wire

// file: tb/can_node_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_node_regs.vh"
module can_node_config_tb_top;
   localparam integer TPM = 1;
   localparam integer FL = `T_FLASH_MS * TPM;
   logic clk_sys, rstn, cyc, stb, we;
   logic [3:0] tens, units, sel, t, u, r;
   logic [7:0] adr;
   logic [31:0] dat, rd, seed;
   wire logic [31:0] dat_o;
   wire logic [3:0] nvm_rate, nvm_wdata, link_rate;
   wire logic [6:0] node;
   wire logic ack, nvm_write, sel_mode, msg, msr, nsg, nsr;
   int n_mismatch, n_checks, n, h, l, i;
   can_node_config #(.TICKS_PER_MS(TPM)) i_dut (.CLK_SYS(clk_sys), .RSTN(rstn),
      .TENS_ROTARY_SWITCH(tens), .UNITS_ROTARY_SWITCH(units), .NVM_RATE(nvm_rate),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .NVM_WRITE(nvm_write),
      .NVM_WDATA(nvm_wdata), .LINK_RATE(link_rate), .NODE_NUMBER(node),
      .SELECT_MODE(sel_mode), .MODULE_STATE_LED_GREEN(msg), .MODULE_STATE_LED_RED(msr),
      .NETWORK_STATE_LED_GREEN(nsg), .NETWORK_STATE_LED_RED(nsr));
   nvm_rate_model i_nvm (.clk(clk_sys), .wr(nvm_write), .wdata(nvm_wdata), .rate(nvm_rate));
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [6:0] node_of(input logic [3:0] a, input logic [3:0] b);
      logic [6:0] v;
      v = 7'(a) * 7'h0a + 7'(b);
      return (v == 7'h00) ? 7'h01 : v;
   endfunction
   function automatic logic led(input int s);
      case (s)
         0: return msg;
         1: return msr;
         2: return nsg;
         default: return nsr;
      endcase
   endfunction
   task automatic test_done;
      if (n_mismatch == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   // classic single cycle; held until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (ack !== 1'b1 && k < 20);
      rd = dat_o;
      chk(k < 20, "no ack");
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic boot(input logic [3:0] a, input logic [3:0] b);
      @(posedge clk_sys);
      rstn <= 1'b0;
      tens <= a;
      units <= b;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (20) @(posedge clk_sys);
   endtask
   // length of the current run of level v, capped so a stuck led cannot hang
   task automatic run(input int s, input logic v, output int len);
      len = 0;
      while (led(s) === v && len < 9000)
      begin
         @(negedge clk_sys);
         len++;
      end
   endtask
   task automatic hi(input int s, output int len);
      run(s, 1'b1, len);
      run(s, 1'b0, len);
      run(s, 1'b1, len);
   endtask
   // sync on the long dark gap, then count flashes up to the next one
   task automatic flashes(input int s, output int cnt);
      int a, b;
      cnt = 0;
      do
      begin
         run(s, 1'b1, a);
         run(s, 1'b0, b);
         cnt++;
      end
      while (b <= 2 * FL && cnt < 12);
      cnt = 0;
      do
      begin
         run(s, 1'b1, a);
         chk(a == FL, "flash width");
         cnt++;
         run(s, 1'b0, b);
      end
      while (b <= 2 * FL && cnt < 12);
   endtask
   task automatic confirm(input logic [3:0] c);
      int k;
      k = 0;
      @(posedge clk_sys);
      units <= c;
      repeat (4) @(posedge clk_sys);
      tens <= 4'h0;
      while (nvm_write !== 1'b1 && k < 50)
      begin
         @(negedge clk_sys);
         k++;
      end
      chk(nvm_write === 1'b1 && nvm_wdata === c, "stored code");
   endtask
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      n_mismatch++;
      test_done;
   end
   initial
   begin
      seed = 32'h74f4_94af;
      n_mismatch = 0;
      n_checks = 0;
      {rstn, cyc, stb, we, adr, dat} = '0;
      sel = 4'hf;
      tens = 4'h9;
      units = 4'h9;
      boot(4'h9, 4'h9);
      chk(sel_mode === 1'b1 && node === 7'h01, "selection entry");
      hi(2, h);
      chk(h == `T_SEL_HALF_MS * TPM, "selection blink");
      @(posedge clk_sys);
      units <= 4'h0;
      flashes(1, n);
      chk(n == 5, "stored rate red count");
      @(posedge clk_sys);
      units <= 4'h3;
      flashes(0, n);
      chk(n == 3, "chosen rate green count");
      confirm(4'h3);
      flashes(1, n);
      chk(n == 3, "confirmed red count");
      for (i = 1; i <= 9; i++)
      begin
         boot(4'h9, 4'h9);
         confirm(4'(i));
      end
      r = 4'(rnd() % 9 + 1);
      boot(4'h9, 4'h9);
      confirm(r);
      boot(4'h5, 4'h7);
      chk(node === 7'h39 && link_rate === r && sel_mode === 1'b0, "boot");
      @(posedge clk_sys);
      tens <= 4'h1;
      units <= 4'h2;
      repeat (30) @(posedge clk_sys);
      chk(node === 7'h39, "node held");
      // a single node on this bench, so numbers never clash
      for (i = 0; i < 6; i++)
      begin
         t = 4'(rnd() % 10);
         u = 4'(rnd() % 10);
         if (t == 4'h9 && u == 4'h9)
            u = 4'h8;
         boot(t, u);
         chk(node === node_of(t, u), "node number");
      end
      boot(4'h9, 4'h8);
      chk(node === node_of(4'h9, 4'h8), "node 98");
      boot(4'h0, 4'h0);
      chk(node === 7'h01, "node zero");
      wb(1'b0, `ADDR_ID, 32'h0000_0000);
      chk(rd === `ID_VALUE, "id");
      wb(1'b0, 8'h20, 32'h0000_0000);
      chk(rd === 32'h0000_0000, "unmapped");
      wb(1'b1, `ADDR_CTRL, 32'h0000_0000);
      hi(0, h);
      chk(h == FL, "running blink");
      wb(1'b1, `ADDR_CTRL, 32'h0000_0001);
      wb(1'b0, `ADDR_CTRL, 32'h0000_0000);
      chk(rd === 32'h0000_0001, "ctrl readback");
      hi(1, h);
      chk(h == `T_ERR_MS * TPM, "error blink");
      for (i = 0; i < 3; i++)
      begin
         wb(1'b1, `ADDR_CTRL, 32'h0000_0002 << i);
         flashes(3, n);
         chk(n == i + 1, "network red count");
      end
      wb(1'b1, `ADDR_CTRL, 32'h0000_0020);
      run(3, 1'b1, h);
      run(3, 1'b0, l);
      chk(l == 9000, "network red off");
      run(2, 1'b1, h);
      chk(h == 9000, "operational steady");
      wb(1'b1, `ADDR_CTRL, 32'h0000_0010);
      hi(2, h);
      chk(h == FL, "preop blink");
      wb(1'b1, `ADDR_CTRL, 32'h0000_0000);
      flashes(2, n);
      chk(n == 1, "stopped flash");
      test_done;
   end
endmodule
`default_nettype wire

// file: tb/nvm_rate_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_rate_model #(
   parameter logic [3:0] INIT_RATE = 4'h5
)
(
   input wire logic clk,
   input wire logic wr,
   input wire logic [3:0] wdata,
   output logic [3:0] rate
);
   initial rate = INIT_RATE;
   // storage ignores node reset, as real flash would across power cycles
   always @(posedge clk)
   begin
      if (wr)
         rate <= wdata;
   end
endmodule
`default_nettype wire
